// File: logic/mal_pkg.sv
package mal_pkg;
  localparam logic [7:0] OFS_CHIP_CFG = 8'h08;
  localparam logic [7:0] OFS_STA_LOW = 8'h10;
  localparam logic [7:0] OFS_STA_MID = 8'h12;
  localparam logic [7:0] OFS_STA_HIGH = 8'h14;
  localparam logic [7:0] OFS_BUS_CTRL = 8'h20;
  localparam logic [7:0] OFS_ROM_CTRL = 8'h22;
  localparam logic [15:0] RST_BUS_CTRL = 16'h0000;
  localparam logic [15:0] RST_ROM_CTRL = 16'h0000;
  localparam logic [15:0] RST_STA = 16'h0000;
  // Serial ROM control bit positions
  localparam int RC_CS = 0;
  localparam int RC_SK = 1;
  localparam int RC_DI = 2;
  localparam int RC_DO = 3;
  localparam int RC_SW_EN = 4;
  localparam logic [15:0] RC_WMASK = 16'h0017;
  // Chip configuration bit positions
  localparam int CC_PRESENT = 0;
  localparam int CC_LOADED = 1;
  // ROM framing
  localparam logic [1:0] ROM_OP_READ = 2'h2;
  localparam logic [1:0] ROM_LAST_WORD = 2'h3;
  localparam logic [4:0] ROM_FIRST_DATA_BIT = 5'h0A;
  localparam logic [4:0] ROM_LAST_BIT = 5'h19;
  // Timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int ROM_SK_HALF_NS = 500;
  localparam int ROM_SK_HALF_INT =
    (ROM_SK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [4:0] ROM_SK_HALF_CYC = 5'(ROM_SK_HALF_INT);
  localparam logic [1:0] STRAP_SETTLE_CYC = 2'h3;
  // SPI command opcodes
  localparam logic [1:0] OP_REG_RD = 2'h0;
  localparam logic [1:0] OP_REG_WR = 2'h1;

  typedef struct packed {
    logic [1:0] op;
    logic [3:0] be;
    logic [5:0] addr;
    logic [3:0] pad;
  } mal_cmd_s;

  typedef enum {MAL_AL_SETTLE, MAL_AL_ISSUE, MAL_AL_BUSY, MAL_AL_DONE}
    mal_al_e;
  typedef enum {MAL_RD_IDLE, MAL_RD_SHIFT} mal_rd_e;
endpackage : mal_pkg

// File: logic/mal_rom_reader.sv
`timescale 1ns/10ps
`default_nettype none
module mal_rom_reader (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic start,
  input wire logic [5:0] addr,
  input wire logic rom_do_s,
  output logic busy,
  output logic done,
  output logic [15:0] data,
  output logic rom_cs,
  output logic rom_sk,
  output logic rom_di
);
  mal_pkg::mal_rd_e st_r;
  logic [4:0] div_r;
  logic [4:0] bit_r;
  logic [8:0] sh_r;
  logic done_r;
  logic cs_r;
  logic sk_r;
  logic [15:0] data_r;

  // Start bit, read opcode and address go out MSB first; data follows a
  // dummy zero, so sampling begins ten clocks of SK into the frame
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= mal_pkg::MAL_RD_IDLE;
      div_r <= 5'h00;
      bit_r <= 5'h00;
      sh_r <= 9'h000;
      done_r <= 1'b0;
      cs_r <= 1'b0;
      sk_r <= 1'b0;
      data_r <= 16'h0000;
    end else if (ce) begin
      done_r <= 1'b0;
      case (st_r)
        mal_pkg::MAL_RD_IDLE: begin
          if (start) begin
            st_r <= mal_pkg::MAL_RD_SHIFT;
            cs_r <= 1'b1;
            sk_r <= 1'b0;
            div_r <= 5'h00;
            bit_r <= 5'h00;
            sh_r <= {1'b1, mal_pkg::ROM_OP_READ, addr};
          end
        end
        mal_pkg::MAL_RD_SHIFT: begin
          if (div_r == mal_pkg::ROM_SK_HALF_CYC - 5'h01) begin
            div_r <= 5'h00;
            sk_r <= ~sk_r;
            if (!sk_r) begin
              if (bit_r >= mal_pkg::ROM_FIRST_DATA_BIT) begin
                data_r <= {data_r[14:0], rom_do_s};
              end
            end else if (bit_r == mal_pkg::ROM_LAST_BIT) begin
              st_r <= mal_pkg::MAL_RD_IDLE;
              cs_r <= 1'b0;
              done_r <= 1'b1;
            end else begin
              bit_r <= bit_r + 5'h01;
              sh_r <= {sh_r[7:0], 1'b0};
            end
          end else begin
            div_r <= div_r + 5'h01;
          end
        end
        default: st_r <= mal_pkg::MAL_RD_IDLE;
      endcase
    end
  end

  assign busy = (st_r != mal_pkg::MAL_RD_IDLE);
  assign done = done_r;
  assign data = data_r;
  assign rom_cs = cs_r;
  assign rom_sk = sk_r;
  assign rom_di = sh_r[8];

  rd_cs_frame_a: assert property (@(posedge clk) disable iff (!arst_n)
    busy |-> cs_r)
    else $error("ROM select dropped inside a read frame");
endmodule : mal_rom_reader
`default_nettype wire

// File: logic/mal_top.sv
`timescale 1ns/10ps
`default_nettype none
module mal_top (
  input wire logic CLK_SYS,
  input wire logic ARST_N,
  input wire logic CE,
  input wire logic ROM_PRESENT_STRAP,
  input wire logic SPI_CS_N,
  input wire logic SPI_SCK,
  input wire logic SPI_MOSI,
  output logic SPI_MISO,
  output logic SPI_MISO_OE,
  output logic ROM_CS,
  output logic ROM_SK,
  output logic ROM_DI,
  input wire logic ROM_DO,
  output logic [47:0] STATION_ADDR
);
  // Pin synchronisers: strap, cs_n, sck, mosi, rom data
  logic [4:0] s1_r;
  logic [4:0] s2_r;
  logic strap_s, cs_n_s, sck_s, mosi_s, rom_do_s;
  logic sck_d_r;
  logic sck_rise, sck_fall;

  logic [1:0] settle_r;
  logic present_r;
  mal_pkg::mal_al_e al_st_r;
  logic [1:0] al_word_r;
  logic rd_start_r;
  logic rd_busy, rd_done;
  logic [15:0] rd_data;
  logic rd_cs, rd_sk, rd_di;
  logic loaded;

  logic [15:0] sta_r [3];
  logic [15:0] bus_ctrl_r;
  logic [15:0] rom_ctrl_r;

  logic [2:0] bit_r;
  logic [7:0] rx_r;
  logic in_cmd_r;
  logic cmd_hi_r;
  logic [7:0] cmd_b1_r;
  mal_pkg::mal_cmd_s cmd_r;
  mal_pkg::mal_cmd_s cmd_new;
  logic [1:0] lane_r;
  logic lane_ok_r;
  logic [7:0] tx_r;
  logic byte_done;
  logic [7:0] rx_byte;
  logic host_we;
  logic [6:0] w_idx;
  logic [2:0] nl_cmd, nl_dat;
  logic [7:0] tx_next;

  function automatic logic [2:0] next_lane(input logic [3:0] be,
                                           input logic [2:0] from);
    logic [2:0] res;
    res = 3'h0;
    for (int i = 3; i >= 0; i--) begin
      if (be[i] && (3'(i) >= from)) begin
        res = {1'b1, 2'(i)};
      end
    end
    return res;
  endfunction : next_lane

  function automatic logic [15:0] rd_word(input logic [6:0] idx);
    logic [15:0] w;
    w = 16'h0000;
    case (idx)
      mal_pkg::OFS_CHIP_CFG[7:1]: begin
        w[mal_pkg::CC_PRESENT] = present_r;
        w[mal_pkg::CC_LOADED] = loaded;
      end
      mal_pkg::OFS_STA_LOW[7:1]: w = sta_r[0];
      mal_pkg::OFS_STA_MID[7:1]: w = sta_r[1];
      mal_pkg::OFS_STA_HIGH[7:1]: w = sta_r[2];
      mal_pkg::OFS_BUS_CTRL[7:1]: w = bus_ctrl_r;
      mal_pkg::OFS_ROM_CTRL[7:1]: begin
        w = rom_ctrl_r & mal_pkg::RC_WMASK;
        w[mal_pkg::RC_DO] = rom_do_s;
      end
      default: w = 16'h0000;
    endcase
    return w;
  endfunction : rd_word

  function automatic logic [7:0] rd_byte(input logic [5:0] a,
                                         input logic [1:0] lane);
    logic [15:0] w;
    w = rd_word({a, lane[1]});
    return lane[0] ? w[15:8] : w[7:0];
  endfunction : rd_byte

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      // Select idles high in both stages, so no false select after reset
      s1_r <= 5'h02;
      s2_r <= 5'h02;
      sck_d_r <= 1'b0;
    end else if (CE) begin
      s1_r <= {ROM_DO, SPI_MOSI, SPI_SCK, SPI_CS_N, ROM_PRESENT_STRAP};
      s2_r <= s1_r;
      sck_d_r <= sck_s;
    end
  end
  assign {rom_do_s, mosi_s, sck_s, cs_n_s, strap_s} = s2_r;
  assign sck_rise = sck_s && !sck_d_r && !cs_n_s;
  assign sck_fall = !sck_s && sck_d_r && !cs_n_s;

  // Strap caught only after the synchronisers have filled
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      settle_r <= 2'h0;
      present_r <= 1'b0;
    end else if (CE && settle_r != mal_pkg::STRAP_SETTLE_CYC) begin
      settle_r <= settle_r + 2'h1;
      if (settle_r == mal_pkg::STRAP_SETTLE_CYC - 2'h1) begin
        present_r <= strap_s;
      end
    end
  end

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      al_st_r <= mal_pkg::MAL_AL_SETTLE;
      al_word_r <= 2'h0;
      rd_start_r <= 1'b0;
    end else if (CE) begin
      rd_start_r <= 1'b0;
      case (al_st_r)
        mal_pkg::MAL_AL_SETTLE: begin
          if (settle_r == mal_pkg::STRAP_SETTLE_CYC) begin
            al_st_r <= present_r ? mal_pkg::MAL_AL_ISSUE
                                 : mal_pkg::MAL_AL_DONE;
          end
        end
        mal_pkg::MAL_AL_ISSUE: begin
          rd_start_r <= 1'b1;
          al_st_r <= mal_pkg::MAL_AL_BUSY;
        end
        mal_pkg::MAL_AL_BUSY: begin
          if (rd_done) begin
            if (al_word_r == mal_pkg::ROM_LAST_WORD) begin
              al_st_r <= mal_pkg::MAL_AL_DONE;
            end else begin
              al_word_r <= al_word_r + 2'h1;
              al_st_r <= mal_pkg::MAL_AL_ISSUE;
            end
          end
        end
        mal_pkg::MAL_AL_DONE: al_st_r <= mal_pkg::MAL_AL_DONE;
        default: al_st_r <= mal_pkg::MAL_AL_DONE;
      endcase
    end
  end
  assign loaded = (al_st_r == mal_pkg::MAL_AL_DONE);

  mal_rom_reader u_reader (
    .clk(CLK_SYS),
    .arst_n(ARST_N),
    .ce(CE),
    .start(rd_start_r),
    .addr({4'h0, al_word_r}),
    .rom_do_s(rom_do_s),
    .busy(rd_busy),
    .done(rd_done),
    .data(rd_data),
    .rom_cs(rd_cs),
    .rom_sk(rd_sk),
    .rom_di(rd_di)
  );

  // SPI slave, mode 0; SCK must stay below a quarter of the system clock
  assign byte_done = sck_rise && (bit_r == 3'h7);
  assign rx_byte = {rx_r[6:0], mosi_s};
  assign cmd_new = {cmd_b1_r, rx_byte};
  assign nl_cmd = next_lane(cmd_new.be, 3'h0);
  assign nl_dat = next_lane(cmd_r.be, {1'b0, lane_r} + 3'h1);
  assign host_we = byte_done && !in_cmd_r && lane_ok_r &&
                   cmd_r.op == mal_pkg::OP_REG_WR;
  assign w_idx = {cmd_r.addr, lane_r[1]};
  // A process, not an assign, so register changes re-evaluate it too
  always_comb begin
    tx_next = in_cmd_r ? rd_byte(cmd_new.addr, nl_cmd[1:0])
                       : rd_byte(cmd_r.addr, nl_dat[1:0]);
  end

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      bit_r <= 3'h0;
      rx_r <= 8'h00;
      in_cmd_r <= 1'b1;
      cmd_hi_r <= 1'b0;
      cmd_b1_r <= 8'h00;
      cmd_r <= '0;
      lane_r <= 2'h0;
      lane_ok_r <= 1'b0;
      tx_r <= 8'h00;
      SPI_MISO <= 1'b0;
      SPI_MISO_OE <= 1'b0;
    end else if (CE) begin
      SPI_MISO_OE <= !cs_n_s;
      if (cs_n_s) begin
        bit_r <= 3'h0;
        in_cmd_r <= 1'b1;
        cmd_hi_r <= 1'b0;
        lane_ok_r <= 1'b0;
      end else if (sck_rise) begin
        rx_r <= rx_byte;
        bit_r <= bit_r + 3'h1;
        if (byte_done && in_cmd_r && !cmd_hi_r) begin
          cmd_b1_r <= rx_byte;
          cmd_hi_r <= 1'b1;
        end else if (byte_done && in_cmd_r) begin
          cmd_r <= cmd_new;
          in_cmd_r <= 1'b0;
          lane_r <= nl_cmd[1:0];
          lane_ok_r <= nl_cmd[2];
          tx_r <= tx_next;
        end else if (byte_done) begin
          lane_r <= nl_dat[1:0];
          lane_ok_r <= lane_ok_r && nl_dat[2];
          tx_r <= tx_next;
        end
      end else if (sck_fall && !in_cmd_r) begin
        SPI_MISO <= tx_r[7];
        tx_r <= {tx_r[6:0], 1'b0};
      end
    end
  end

  // A station word from the automatic load wins over a host write in the same cycle
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      for (int i = 0; i < 3; i++) begin
        sta_r[i] <= mal_pkg::RST_STA;
      end
    end else if (CE) begin
      if (al_st_r == mal_pkg::MAL_AL_BUSY && rd_done &&
          al_word_r != 2'h0) begin
        sta_r[al_word_r - 2'h1] <= rd_data;
      end else if (host_we) begin
        for (int i = 0; i < 3; i++) begin
          if (w_idx == mal_pkg::OFS_STA_LOW[7:1] + 7'(i)) begin
            if (lane_r[0]) begin
              sta_r[i][15:8] <= rx_byte;
            end else begin
              sta_r[i][7:0] <= rx_byte;
            end
          end
        end
      end
    end
  end

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      bus_ctrl_r <= mal_pkg::RST_BUS_CTRL;
    end else if (CE && host_we && w_idx == mal_pkg::OFS_BUS_CTRL[7:1]) begin
      if (lane_r[0]) begin
        bus_ctrl_r[15:8] <= rx_byte;
      end else begin
        bus_ctrl_r[7:0] <= rx_byte;
      end
    end
  end

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      rom_ctrl_r <= mal_pkg::RST_ROM_CTRL;
    end else if (CE && host_we && w_idx == mal_pkg::OFS_ROM_CTRL[7:1]) begin
      if (lane_r[0]) begin
        rom_ctrl_r[15:8] <= rx_byte & mal_pkg::RC_WMASK[15:8];
      end else begin
        rom_ctrl_r[7:0] <= rx_byte & mal_pkg::RC_WMASK[7:0];
      end
    end
  end

  // Software bit-banging is locked out until the automatic load finishes
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      ROM_CS <= 1'b0;
      ROM_SK <= 1'b0;
      ROM_DI <= 1'b0;
    end else if (CE) begin
      if (loaded && rom_ctrl_r[mal_pkg::RC_SW_EN]) begin
        ROM_CS <= rom_ctrl_r[mal_pkg::RC_CS];
        ROM_SK <= rom_ctrl_r[mal_pkg::RC_SK];
        ROM_DI <= rom_ctrl_r[mal_pkg::RC_DI];
      end else begin
        ROM_CS <= rd_cs;
        ROM_SK <= rd_sk;
        ROM_DI <= rd_di;
      end
    end
  end

  assign STATION_ADDR = {sta_r[2], sta_r[1], sta_r[0]};

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!ARST_N);

  no_strap_load_a: assert property (!present_r |-> !rd_start_r)
    else $error("ROM read started without the strap");
  load_range_a: assert property (rd_busy |-> present_r &&
    al_st_r == mal_pkg::MAL_AL_BUSY)
    else $error("ROM read outside the automatic load");
  load_words_a: assert property (CE && rd_done && al_word_r == 2'h2 &&
    al_st_r == mal_pkg::MAL_AL_BUSY |=> sta_r[1] == $past(rd_data))
    else $error("Word 2 not placed in station address middle");
  word0_skip_a: assert property (CE && rd_done && al_word_r == 2'h0 &&
    !host_we |=> $stable(STATION_ADDR))
    else $error("Reserved word 0 changed the station address");
  load_done_a: assert property ($rose(loaded) && present_r |->
    $past(al_word_r) == 2'h3)
    else $error("Automatic load ended before word 3");
  sw_pins_a: assert property (CE && loaded &&
    rom_ctrl_r[mal_pkg::RC_SW_EN] |=>
    ROM_CS == $past(rom_ctrl_r[mal_pkg::RC_CS]))
    else $error("ROM select not following software control");
  lane_enabled_a: assert property (host_we |-> cmd_r.be[lane_r])
    else $error("Write on a lane that is not enabled");
  host_write_a: assert property (CE && host_we &&
    w_idx != mal_pkg::OFS_CHIP_CFG[7:1] &&
    w_idx != mal_pkg::OFS_ROM_CTRL[7:1] &&
    !(al_st_r == mal_pkg::MAL_AL_BUSY && rd_done) |=>
    rd_byte($past(cmd_r.addr), $past(lane_r)) == $past(rx_byte) ||
    $past(rd_word(w_idx)) == 16'h0000 && rd_word($past(w_idx)) == 16'h0000)
    else $error("Host byte write not stored");
  cfg_ro_a: assert property (CE && host_we &&
    w_idx == mal_pkg::OFS_CHIP_CFG[7:1] |=>
    rd_word(mal_pkg::OFS_CHIP_CFG[7:1]) ==
    $past(rd_word(mal_pkg::OFS_CHIP_CFG[7:1])))
    else $error("Chip configuration accepted a write");
  miso_oe_a: assert property (cs_n_s && CE |=> !SPI_MISO_OE)
    else $error("MISO driven while deselected");

  autoload_c: cover property (present_r && $rose(loaded));
  host_wr_c: cover property (host_we && w_idx == mal_pkg::OFS_STA_HIGH[7:1]);
  host_rd_c: cover property (byte_done && !in_cmd_r &&
    cmd_r.op == mal_pkg::OP_REG_RD);
  sw_rom_c: cover property (loaded && rom_ctrl_r[mal_pkg::RC_SW_EN]);
endmodule : mal_top
`default_nettype wire

// File: sim/mal_rom_model.sv
`timescale 1ns/10ps
`default_nettype none
module mal_rom_model (
  input wire logic cs,
  input wire logic sk,
  input wire logic di,
  output logic do_o
);
  // One 16-bit word per address, 64 addresses
  logic [15:0] mem [64];
  logic [5:0] adr;
  int k;
  initial begin
    for (int i = 0; i < 64; i++) begin
      // Bytes differ within each word, so a byte swap shows up
      mem[i] = 16'(i * 16'h0102) ^ 16'hA05F;
    end
    do_o = 1'b1;
    adr = 6'h00;
    k = 0;
  end
  // Start bit, opcode and address all shift in; only the last six stay
  always @(posedge sk) begin
    if (cs) begin
      if (k < 9) begin
        adr <= {adr[4:0], di};
      end
      k <= k + 1;
    end
  end
  // Dummy zero, then data MSB first after each fall
  always @(negedge sk) begin
    if (cs) begin
      do_o <= (k >= 10 && k <= 25) ? mem[adr][25 - k] : 1'b0;
    end
  end
  // Released line is not left holding the last bit
  always @(negedge cs) begin
    k <= 0;
    do_o <= ~do_o;
  end
endmodule : mal_rom_model
`default_nettype wire

// File: sim/mal_top_tb.sv
`timescale 1ns/10ps
`default_nettype none
module mal_top_tb;
  typedef struct {
    logic [1:0] op;
    logic [3:0] be;
    logic [5:0] a;
    logic [31:0] wd;
    logic [31:0] ex;
    logic [31:0] mk;
  } mal_row_s;
  logic clk, arst_n, strap, cs_n, sck, mosi;
  logic miso, miso_oe, rcs, rsk, rdi, rdo;
  logic [47:0] sta;
  logic [31:0] rv;
  logic [15:0] w1, w2, w3;
  mal_row_s rows [14];
  int n_fail = 0;
  int check_count = 0;
  int frames = 0;
  bit ok;

  mal_top dut_u (.CLK_SYS(clk), .ARST_N(arst_n), .CE(1'b1),
    .ROM_PRESENT_STRAP(strap), .SPI_CS_N(cs_n), .SPI_SCK(sck),
    .SPI_MOSI(mosi), .SPI_MISO(miso), .SPI_MISO_OE(miso_oe),
    .ROM_CS(rcs), .ROM_SK(rsk), .ROM_DI(rdi), .ROM_DO(rdo),
    .STATION_ADDR(sta));
  mal_rom_model rom_u (.cs(rcs), .sk(rsk), .di(rdi), .do_o(rdo));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge rcs) frames++;

  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  // Slow SCK keeps every bit well clear of the input synchroniser
  task automatic sbit(input logic b, output logic r);
    mosi <= b;
    cyc(6);
    r = miso;
    sck <= 1'b1;
    cyc(6);
    sck <= 1'b0;
  endtask : sbit

  task automatic spi(input logic [1:0] op, input logic [3:0] be,
      input logic [5:0] a, input logic [31:0] wd);
    logic [15:0] c;
    logic b;
    c = {op, be, a, 4'h0};
    rv = '0;
    cs_n <= 1'b0;
    cyc(6);
    chk(miso_oe, 1'b1);
    for (int i = 15; i >= 0; i--) sbit(c[i], b);
    for (int l = 0; l < 4; l++) begin
      if (be[l]) begin
        for (int i = 7; i >= 0; i--) begin
          sbit(wd[8 * l + i], b);
          rv[8 * l + i] = b;
        end
      end
    end
    cyc(6);
    cs_n <= 1'b1;
    cyc(10);
  endtask : spi

  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : close_out

  task automatic wait_load;
    ok = 0;
    for (int i = 0; i < 40 && !ok; i++) begin
      spi(2'h0, 4'h3, 6'h02, 32'h0);
      ok = rv[1];
    end
    if (!ok) begin
      n_fail++;
      $display("mismatch at %0t: load never finished", $time);
      close_out();
    end
  endtask : wait_load

  initial begin
    arst_n = 1'b0;
    strap = 1'b1;
    cs_n = 1'b1;
    sck = 1'b0;
    mosi = 1'b0;
    cyc(10);
    arst_n <= 1'b1;
    wait_load();
    w1 = rom_u.mem[1];
    w2 = rom_u.mem[2];
    w3 = rom_u.mem[3];
    chk(frames, 4);
    chk(sta, {w3, w2, w1});
    rows = '{
      '{2'h0, 4'h3, 6'h02, 0, 32'h3, 32'h3},
      '{2'h0, 4'hF, 6'h04, 0, {w2, w1}, '1},
      '{2'h0, 4'h3, 6'h05, 0, w3, 32'hFFFF},
      '{2'h0, 4'h3, 6'h08, 0, 32'h0, 32'hFFFF},
      '{2'h1, 4'h3, 6'h08, 32'h5AA5, 0, 0},
      '{2'h0, 4'h3, 6'h08, 0, 32'h5AA5, 32'hFFFF},
      '{2'h1, 4'h3, 6'h02, 32'hFFFF, 0, 0},
      '{2'h0, 4'h3, 6'h02, 0, 32'h3, 32'h3},
      '{2'h1, 4'h2, 6'h04, 32'hC300, 0, 0},
      '{2'h0, 4'h2, 6'h04, 0, 32'hC300, 32'hFF00},
      '{2'h0, 4'h1, 6'h04, 0, w1[7:0], 32'hFF},
      '{2'h0, 4'hC, 6'h08, 0, 32'h0, 32'hFFF70000},
      '{2'h1, 4'hF, 6'h00, '1, 0, 0},
      '{2'h0, 4'hF, 6'h00, 0, 32'h0, '1}
    };
    foreach (rows[i]) begin
      spi(rows[i].op, rows[i].be, rows[i].a, rows[i].wd);
      if (rows[i].mk != 0) chk(rv & rows[i].mk, rows[i].ex);
    end
    // Software drives the ROM pins once the load is over
    spi(2'h1, 4'hC, 6'h08, 32'h00110000);
    chk(rcs, 1'b1);
    spi(2'h1, 4'hC, 6'h08, 32'h00170000);
    chk({rsk, rdi}, 2'b11);
    spi(2'h0, 4'hC, 6'h08, 0);
    chk(rv[20:16], {1'b1, rdo, 3'b111});
    spi(2'h1, 4'hC, 6'h08, 32'h0);
    // Second reset with no ROM fitted
    arst_n <= 1'b0;
    strap <= 1'b0;
    cyc(10);
    arst_n <= 1'b1;
    frames = 0;
    cyc(3000);
    chk(frames, 0);
    spi(2'h0, 4'h3, 6'h02, 0);
    chk(rv[1:0], 2'b10);
    spi(2'h1, 4'hF, 6'h04, 32'h89ABCDEF);
    spi(2'h1, 4'h3, 6'h05, 32'h0123);
    chk(sta, 48'h0123_89AB_CDEF);
    spi(2'h0, 4'hF, 6'h04, 0);
    chk(rv, 32'h89ABCDEF);
    close_out();
  end
endmodule : mal_top_tb
`default_nettype wire
